/* File: design/rea_energy_acc.sv */
`timescale 1ns/1ps
// reactive power post-processing, energy accumulator and status registers
// How it works
// R1: reactive power input is signed; positive for 0..+90 degrees, negative otherwise.
// R2: direction bit clear: flag sign change from positive to negative.
// R3: direction bit set: flag sign change from negative to positive.
// R4: enabled sign flag drives interrupt until flag is cleared.
// R5: below no-load threshold, no accumulation and no-load flag set.
// R6: enabled no-load flag drives interrupt until software clears it.
// R7: no-load field 00 off, 01/10/11 pick three decreasing thresholds.
// R8: 49-bit signed accumulator; upper 24 bits form readable energy.
// R9: one accumulation update every five master clocks.
// R10: neither mode bit set: signed accumulation.
// R11: both mode bits set: absolute mode wins.
// R12: anti-tamper adds or subtracts by active power sign.
// R13: absolute mode accumulates magnitude; both modes off after reset.
// R14: divide by 8-bit divisor; zero behaves as one.
// R15: read-to-clear read returns energy then clears upper 24 bits.
// R16: energy wraps naturally at signed 24-bit limits.
// R17: half-full both directions and overflow/underflow raise events.
// R18: active-low pulse output follows gain-corrected power and mode.
// R19: waveform samples at four selectable rates when enabled.
// R20: after reset signed accumulation of reactive power alone.
// R21: power scaled by one plus signed 12-bit gain over 4096.
// R22: signed 16-bit offset added, 256 LSBs per waveform LSB.
// R23: sign change compares each new sample sign with the previous.
// R24: software clears flags and reads energy before it wraps.
module rea_energy_acc
   import rea_pkg::*;
(
   input  wire logic                 sys_clk,     // master clock, 25 MHz
   input  wire logic                 nrst,        // async reset, active low
   input  wire logic [7:0]           regAddr,     // register address
   input  wire logic [23:0]          regWdata,    // register write data
   input  wire logic                 regWr,       // write strobe
   input  wire logic                 regRd,       // read strobe
   output logic      [23:0]          regRdata,    // read data, cycle after strobe
   input  wire logic [POWER_W-1:0]   varPower,    // filtered reactive power, signed
   input  wire logic                 activeNeg,   // active power sign, 1 = negative
   output logic                      measIrq,     // measurement interrupt, active high
   output logic                      energyPulseN // reactive pulse output, active low
);
   import rea_pkg::*;

   // configuration and status
   logic [7:0]  waveSel_r, noLoadCfg_r, accumulation_mode_config_r, irqEn1_r, irqEn3_r, irqSt1_r;
   logic [7:0]  divisor_r, waveRate_r;
   logic [11:0] gain_r;
   logic [15:0] offset_r;
   logic [ACC_W-1:0] acc_r, acc_nxt;
   logic [2:0]  phase_r;
   logic        prevNeg_r;
   logic [7:0]  divCnt_r;
   logic [7:0]  waveCnt_r;
   logic [23:0] waveData_r;
   logic [23:0] rdata_r;

   // input sample re-registered on every clock, not held between updates
   logic [POWER_W-1:0] sample_r;
   logic               actNegS1_r, actNegS2_r;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sample_r   <= '0;
         actNegS1_r <= 1'b0;
         actNegS2_r <= 1'b0;
      end else begin
         sample_r   <= varPower; // R1
         actNegS1_r <= activeNeg;
         actNegS2_r <= actNegS1_r;
      end
   end

   // update strobe every five clocks
   wire tick = (phase_r == UPDATE_LAST); // R9

   // gain: p * (1 + g/4096) computed as p + (p*g)>>>12
   wire signed [POWER_W-1:0] pIn     = signed'(sample_r);
   wire signed [11:0]        gSigned = signed'(gain_r);
   wire signed [POWER_W+11:0] prod   = pIn * gSigned;
   wire signed [POWER_W+1:0] gained  = (POWER_W+2)'(pIn) + (POWER_W+2)'(prod >>> 12); // R21
   // offset in 1/256 of a sample LSB: scale sample up by 8 bits first
   wire signed [POWER_W+9:0] withOfs = {gained, 8'h00}
                                     + (POWER_W+10)'(signed'(offset_r)); // R22
   wire signed [POWER_W+1:0] corr    = withOfs[POWER_W+9:8];
   wire                      corrNeg = corr[POWER_W+1];
   wire        [POWER_W+1:0] corrMag = corrNeg ? (POWER_W+2)'(-corr) : corr;

   // no-load threshold selection
   wire [1:0]  nlSel = noLoadCfg_r[NL_FIELD_LSB +: 2];
   wire [23:0] nlThresh = (nlSel == 2'b01) ? NL_THRESH_1 :
                          (nlSel == 2'b10) ? NL_THRESH_2 : NL_THRESH_3; // R7
   wire noLoad = (nlSel != 2'b00) && (corrMag < {2'b00, nlThresh}); // R5

   // mode decode; absolute has priority when both are set
   wire modeAbs    = accumulation_mode_config_r[ACC_ABS_BIT]; // R11
   wire modeTamper = accumulation_mode_config_r[ACC_TAMPER_BIT] && !modeAbs;
   rea_mode_type mode;
   assign mode = modeAbs ? ACC_ABSOLUTE : (modeTamper ? ACC_TAMPER : ACC_SIGNED); // R20

   // divider: the step is taken only on every divisor-th tick (0 acts as 1)
   wire [7:0] divLimit = (divisor_r == 8'h00) ? 8'h01 : divisor_r; // R14
   wire       divHit   = (divCnt_r + 8'h01 >= divLimit);

   // signed step according to mode
   logic signed [POWER_W+1:0] step;
   always_comb begin
      case (mode)
         ACC_SIGNED:   step = corr; // R10
         ACC_TAMPER:   step = actNegS2_r ? (POWER_W+2)'(-corr) : corr; // R12
         ACC_ABSOLUTE: step = signed'(corrMag); // R13
         default:      step = corr;
      endcase
   end

   wire doAcc = tick && divHit && !noLoad; // R5
   wire [ACC_W-1:0] stepExt = ACC_W'(step);
   wire [ACC_W-1:0] accSum  = acc_r + stepExt; // R16

   // energy view and its boundary crossings
   wire [ENERGY_W-1:0] eOld = acc_r[ACC_W-1 -: ENERGY_W]; // R8
   wire [ENERGY_W-1:0] eNew = accSum[ACC_W-1 -: ENERGY_W];
   wire stepPos  = !step[POWER_W+1];
   wire ovfEv    = doAcc && stepPos && !eOld[23] && eNew[23]; // R17
   wire unfEv    = doAcc && !stepPos && eOld[23] && !eNew[23];
   wire halfPos  = doAcc && !eOld[22] && eNew[22] && !eNew[23];
   wire halfNeg  = doAcc && eOld[22] && !eNew[22] && eNew[23];

   // sign change on the update stream
   wire curNeg   = corrNeg;
   wire signEv   = tick && (accumulation_mode_config_r[ACC_SIGN_DIR_BIT] ? (prevNeg_r && !curNeg)  // R3
                                                         : (!prevNeg_r && curNeg)); // R2 R23

   // waveform decimation: rate code 0..3 sets a limit of 1,2,4,8 x base, one sample per limit+1 updates
   wire [7:0] waveLimit = WAVE_DIV_BASE << waveRate_r[1:0];
   wire       waveOn    = irqEn3_r[EN3_WAVEFORM_SAMPLING_ENABLE_BIT];
   wire       waveEv    = waveOn && tick && (waveCnt_r >= waveLimit); // R19

   // register decode
   wire wrWave  = regWr && (regAddr == ADDR_WAVE_SEL);
   wire wrNl    = regWr && (regAddr == ADDR_NOLOAD_CFG);
   wire wrMode  = regWr && (regAddr == ADDR_ACC_MODE);
   wire wrEn1   = regWr && (regAddr == ADDR_IRQ_EN1);
   wire wrEn3   = regWr && (regAddr == ADDR_IRQ_EN3);
   wire wrSt1   = regWr && (regAddr == ADDR_IRQ_ST1);
   wire wrDiv   = regWr && (regAddr == ADDR_DIVISOR);
   wire wrGain  = regWr && (regAddr == ADDR_GAIN);
   wire wrOfs   = regWr && (regAddr == ADDR_OFFSET);
   wire wrRate  = regWr && (regAddr == ADDR_WAVE_RATE);
   wire rdClear = regRd && (regAddr == ADDR_ENERGY_RC);

   // event vector; hardware set beats a same-cycle write-one clear
   wire [7:0] setVec = {1'b0, waveEv, unfEv, ovfEv, halfNeg, halfPos, noLoad && tick, signEv};
   wire [7:0] clrVec = wrSt1 ? regWdata[7:0] : 8'h00;

   always_comb begin
      acc_nxt = acc_r;
      if (rdClear) begin
         // clear upper bits; a same-cycle step keeps only its fraction
         acc_nxt = {{ENERGY_W{1'b0}}, (doAcc ? accSum[ACC_W-ENERGY_W-1:0]
                                             : acc_r[ACC_W-ENERGY_W-1:0])}; // R15
      end else if (doAcc) begin
         acc_nxt = accSum; // R8
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         phase_r   <= 3'h0;
         divCnt_r  <= 8'h00;
         prevNeg_r <= 1'b0;
         waveCnt_r <= 8'h00;
         acc_r     <= '0;
      end else begin
         phase_r <= tick ? 3'h0 : phase_r + 3'h1;
         if (tick) begin
            divCnt_r  <= divHit ? 8'h00 : divCnt_r + 8'h01;
            prevNeg_r <= curNeg; // R23
            waveCnt_r <= (waveCnt_r >= waveLimit) ? 8'h00 : waveCnt_r + 8'h01;
         end
         acc_r <= acc_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         waveSel_r   <= RST_BYTE;
         noLoadCfg_r <= RST_BYTE;
         accumulation_mode_config_r   <= RST_BYTE; // R13
         irqEn1_r    <= RST_BYTE;
         irqEn3_r    <= RST_BYTE;
         irqSt1_r    <= RST_BYTE;
         divisor_r   <= RST_BYTE;
         waveRate_r  <= RST_BYTE;
         gain_r      <= RST_GAIN;
         offset_r    <= RST_OFFSET;
         waveData_r  <= 24'h00_0000;
      end else begin
         if (wrWave) waveSel_r   <= regWdata[7:0];
         if (wrNl)   noLoadCfg_r <= regWdata[7:0];
         if (wrMode) accumulation_mode_config_r   <= regWdata[7:0];
         if (wrEn1)  irqEn1_r    <= regWdata[7:0];
         if (wrEn3)  irqEn3_r    <= regWdata[7:0];
         if (wrDiv)  divisor_r   <= regWdata[7:0];
         if (wrRate) waveRate_r  <= regWdata[7:0];
         if (wrGain) gain_r      <= regWdata[11:0];
         if (wrOfs)  offset_r    <= regWdata[15:0];
         irqSt1_r <= (irqSt1_r & ~clrVec) | setVec; // R4 R6
         if (waveEv) waveData_r <= corr[POWER_W-1:0]; // R19
      end
   end

   // flag stays high until cleared, so the interrupt follows it
   assign measIrq = |(irqSt1_r & irqEn1_r); // R4 R6

   // read mux, registered for the one-cycle read latency
   logic [23:0] rdMux;
   always_comb begin
      case (regAddr)
         ADDR_WAVE_SEL:   rdMux = {16'h0000, waveSel_r};
         ADDR_NOLOAD_CFG: rdMux = {16'h0000, noLoadCfg_r};
         ADDR_ACC_MODE:   rdMux = {16'h0000, accumulation_mode_config_r};
         ADDR_IRQ_EN1:    rdMux = {16'h0000, irqEn1_r};
         ADDR_IRQ_EN3:    rdMux = {16'h0000, irqEn3_r};
         ADDR_IRQ_ST1:    rdMux = {16'h0000, irqSt1_r};
         ADDR_ENERGY:     rdMux = eOld;
         ADDR_ENERGY_RC:  rdMux = eOld; // R15
         ADDR_DIVISOR:    rdMux = {16'h0000, divisor_r};
         ADDR_GAIN:       rdMux = {12'h000, gain_r};
         ADDR_OFFSET:     rdMux = {8'h00, offset_r};
         ADDR_WAVE_DATA:  rdMux = waveData_r;
         ADDR_WAVE_RATE:  rdMux = {16'h0000, waveRate_r};
         default:         rdMux = 24'h00_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) rdata_r <= 24'h00_0000;
      else if (regRd) rdata_r <= rdMux;
      else rdata_r <= 24'h00_0000;
   end
   assign regRdata = rdata_r;

   // pulse path sees the same gated, mode-shaped step as the accumulator
   rea_pulse_gen u_pulse (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .stepValid (doAcc),
      .stepMag   (step[POWER_W+1] ? POWER_W'(-step) : step[POWER_W-1:0]),
      .pulseN    (energyPulseN) // R18
   );
endmodule

/* File: design/rea_pulse_gen.sv */
`timescale 1ns/1ps
// energy-to-pulse converter: active-low pulse whose rate follows accumulated magnitude
module rea_pulse_gen
   import rea_pkg::*;
(
   input  wire logic                 sys_clk,   // master clock
   input  wire logic                 nrst,      // async reset, active low
   input  wire logic                 stepValid, // one accumulation step
   input  wire logic [POWER_W-1:0]   stepMag,   // magnitude of the step
   output logic                      pulseN     // active-low pulse output
);
   import rea_pkg::*;

   logic [POWER_W+7:0] bucket_r;
   logic [3:0]         width_r;
   wire  [POWER_W+8:0] bucketSum = {1'b0, bucket_r} + {9'h0_00, stepMag};
   wire                fire      = stepValid && bucketSum[POWER_W+8];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bucket_r <= '0;
         width_r  <= 4'h0;
      end else begin
         if (stepValid) bucket_r <= bucketSum[POWER_W+7:0];
         if (fire) width_r <= 4'hF;
         else if (width_r != 4'h0) width_r <= width_r - 4'h1;
      end
   end

   // held low for a fixed width so an LED sees it
   assign pulseN = (width_r == 4'h0); // R18
endmodule

/* File: inc/rea_pkg.sv */
// package: register map, field positions, reset values and timing for the reactive energy block
package rea_pkg;
   // register addresses on the plain register port
   localparam logic [7:0] ADDR_WAVE_SEL   = 8'h0d;
   localparam logic [7:0] ADDR_NOLOAD_CFG = 8'h0e;
   localparam logic [7:0] ADDR_ACC_MODE   = 8'h0f;
   localparam logic [7:0] ADDR_IRQ_EN1    = 8'hd9;
   localparam logic [7:0] ADDR_IRQ_EN3    = 8'hdb;
   localparam logic [7:0] ADDR_IRQ_ST1    = 8'hdc;
   localparam logic [7:0] ADDR_ENERGY     = 8'h40;
   localparam logic [7:0] ADDR_ENERGY_RC  = 8'h41;
   localparam logic [7:0] ADDR_DIVISOR    = 8'h42;
   localparam logic [7:0] ADDR_GAIN       = 8'h43;
   localparam logic [7:0] ADDR_OFFSET     = 8'h44;
   localparam logic [7:0] ADDR_WAVE_DATA  = 8'h45;
   localparam logic [7:0] ADDR_WAVE_RATE  = 8'h46;

   // accumulation mode fields
   localparam int ACC_SIGN_DIR_BIT = 0;
   localparam int ACC_TAMPER_BIT   = 1;
   localparam int ACC_ABS_BIT      = 2;
   // no-load field position (two bits)
   localparam int NL_FIELD_LSB     = 2;
   // irq enable 3 waveform sampling enable
   localparam int EN3_WAVEFORM_SAMPLING_ENABLE_BIT     = 0;
   // status / enable one bit positions
   localparam int ST_SIGN_BIT      = 0;
   localparam int ST_NOLOAD_BIT    = 1;
   localparam int ST_HALF_POS_BIT  = 2;
   localparam int ST_HALF_NEG_BIT  = 3;
   localparam int ST_OVF_BIT       = 4;
   localparam int ST_UNF_BIT       = 5;
   localparam int ST_WAVE_BIT      = 6;

   // reset values
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [11:0] RST_GAIN   = 12'h000;
   localparam logic [15:0] RST_OFFSET = 16'h0000;

   // accumulation widths
   localparam int ACC_W    = 49;
   localparam int ENERGY_W = 24;
   localparam int POWER_W  = 24;

   // one update every five master clocks
   localparam int          UPDATE_PERIOD = 5;
   localparam logic [2:0]  UPDATE_LAST   = 3'(UPDATE_PERIOD - 1);

   // no-load thresholds as fractions of a 24-bit full scale (parts-per-million scale)
   localparam logic [23:0] FULL_SCALE  = 24'h7F_FFFF;
   localparam logic [23:0] NL_THRESH_1 = 24'(64'h0000_0000_007F_FFFF * 150 / 1000000);
   localparam logic [23:0] NL_THRESH_2 = 24'(64'h0000_0000_007F_FFFF * 75 / 1000000);
   localparam logic [23:0] NL_THRESH_3 = 24'(64'h0000_0000_007F_FFFF * 37 / 1000000);

   // waveform rates: decimation of the update stream
   localparam logic [7:0]  WAVE_DIV_BASE = 8'h07;

   typedef enum logic [1:0] {
      ACC_SIGNED, ACC_TAMPER, ACC_ABSOLUTE
   } rea_mode_type;
endpackage

/* File: tb/rea_energy_acc_sva.sv */
// checker: port-level properties of the reactive energy block
`timescale 1ns/1ps
module rea_energy_acc_sva (
   input wire logic                        sys_clk,     // master clock
   input wire logic                        nrst,        // reset, active low
   input wire logic [7:0]                  regAddr,     // address
   input wire logic [23:0]                 regWdata,    // write data
   input wire logic                        regWr,       // write strobe
   input wire logic                        regRd,       // read strobe
   input wire logic [23:0]                 regRdata,    // read data
   input wire logic [rea_pkg::POWER_W-1:0] varPower,    // reactive power
   input wire logic                        activeNeg,   // active sign
   input wire logic                        measIrq,     // interrupt
   input wire logic                        energyPulseN // pulse, active low
);
   import rea_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire rdEnergy = regRd && regAddr == ADDR_ENERGY;
   wire rdClear  = regRd && regAddr == ADDR_ENERGY_RC;
   wire wrIrq    = regWr && (regAddr == ADDR_IRQ_ST1 || regAddr == ADDR_IRQ_EN1);

   chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 24'h00_0000)
      else $error("read data not zero outside read cycle");
   chk_irq_hold: assert property (measIrq && !wrIrq |=> measIrq)
      else $error("interrupt dropped without a clear");
   chk_irq_masked: assert property (regWr && regAddr == ADDR_IRQ_EN1 && regWdata[7:0] == 8'h00
      |=> !measIrq)
      else $error("interrupt stays with all enables off");
   chk_pulse_width: assert property ($fell(energyPulseN) |-> !energyPulseN [*8])
      else $error("pulse output low too briefly");
   chk_clear_energy: assert property (rdClear ##1 rdEnergy
      |=> regRdata inside {24'h00_0000, 24'h00_0001, 24'hFF_FFFF})
      else $error("energy not cleared by read-clear");
   chk_energy_step: assert property (rdEnergy ##1 rdEnergy
      |=> 24'(regRdata - $past(regRdata)) inside {24'h00_0000, 24'h00_0001, 24'hFF_FFFF})
      else $error("energy moved by more than one count");
   chk_div_readback: assert property (regWr && regAddr == ADDR_DIVISOR
      ##1 regRd && regAddr == ADDR_DIVISOR |=> regRdata[7:0] == $past(regWdata[7:0], 2))
      else $error("divisor readback wrong");
   chk_mode_readback: assert property (regWr && regAddr == ADDR_ACC_MODE
      ##1 regRd && regAddr == ADDR_ACC_MODE |=> regRdata[2:0] == $past(regWdata[2:0], 2))
      else $error("mode readback wrong");
   cover property ($rose(measIrq));
   cover property ($fell(energyPulseN));
   cover property (rdClear ##1 rdEnergy);
   cover property (regWr ##1 regRd);
endmodule

bind rea_energy_acc rea_energy_acc_sva rea_energy_acc_sva_inst (.sys_clk(sys_clk),
   .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .varPower(varPower), .activeNeg(activeNeg), .measIrq(measIrq),
   .energyPulseN(energyPulseN));

/* File: tb/rea_power_src.sv */
// power source model: filtered reactive power and active sign, launched after the edge
`timescale 1ns/1ps
module rea_power_src (
   input  wire logic                        sys_clk,   // master clock
   input  wire logic                        nrst,      // reset, active low
   input  wire logic [rea_pkg::POWER_W-1:0] level,     // requested power
   input  wire logic                        negActive, // requested active sign
   output logic      [rea_pkg::POWER_W-1:0] varPower,  // power to the block
   output logic                             activeNeg  // active sign to the block
);
   import rea_pkg::*;
   // registered so the sample changes only in the nonblocking update after each edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         varPower  <= '0;
         activeNeg <= 1'b0;
      end else begin
         varPower  <= level;
         activeNeg <= negActive;
      end
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the reactive energy block
`timescale 1ns/1ps
module testbench;
   import rea_pkg::*;
   localparam logic [23:0] QP = 24'h40_0000; // one energy count per 8 updates
   localparam logic [23:0] QN = 24'hC0_0000;
   logic [7:0]  regAddr;
   logic [23:0] regWdata, regRdata, level, varPower, d0, d1;
   logic        sys_clk, nrst, regWr, regRd, negActive, activeNeg, measIrq, energyPulseN;
   int          badCount, nTests, pulses;
   logic [7:0]  rwAddr [6] = '{ADDR_WAVE_SEL, ADDR_NOLOAD_CFG, ADDR_ACC_MODE,
                                 ADDR_IRQ_EN1, ADDR_IRQ_EN3, ADDR_DIVISOR};
   // mode, divisor, gain, active sign, power, expected energy
   logic [23:0] accTab [8][6] = '{'{0, 0, 0, 0, QP, 24'h00_000A}, '{0, 0, 0, 0, QN, 24'hFF_FFF6},
      '{0, 2, 0, 0, QP, 24'h00_0005}, '{0, 0, 24'h00_0800, 0, QP, 24'h00_0005},
      '{2, 0, 0, 1, QP, 24'hFF_FFF6}, '{2, 0, 0, 0, QP, 24'h00_000A},
      '{4, 0, 0, 0, QN, 24'h00_000A}, '{6, 0, 0, 1, QP, 24'h00_000A}};
   // no-load field, power, expected flag; powers 24'h00_0400 and 24'h00_0200 sit between neighbouring thresholds
   logic [23:0] nlTab [8][3] = '{'{1, 1, 1}, '{1, 24'h00_0400, 1}, '{2, 24'h00_0400, 0},
      '{2, 24'h00_0200, 1}, '{3, 24'h00_0200, 0}, '{3, 1, 1}, '{0, 1, 0},
      '{1, 24'h00_1000, 0}};

   rea_power_src rea_power_src_inst (.sys_clk(sys_clk), .nrst(nrst), .level(level),
      .negActive(negActive), .varPower(varPower), .activeNeg(activeNeg));
   rea_energy_acc rea_energy_acc_inst (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .varPower(varPower), .activeNeg(activeNeg), .measIrq(measIrq),
      .energyPulseN(energyPulseN));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(negedge energyPulseN) pulses++;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      nTests++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // update phase and leftover low bits allow one count either way
   task automatic near(input logic [23:0] seen, input logic [23:0] exp);
      logic [23:0] d;
      d = seen - exp;
      check((d inside {24'h00_0000, 24'h00_0001, 24'hFF_FFFF}) ? exp : seen, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   // write strobe followed at once by a read strobe, so readback meets no gap
   task automatic wrRd(input logic [7:0] a, input logic [23:0] d, output logic [23:0] x);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 x = regRdata;
   endtask
   task automatic rd2(input logic [7:0] a, b, output logic [23:0] x, y);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regAddr <= b;
      #1 x = regRdata;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 y = regRdata;
   endtask
   task automatic hold(input logic [23:0] p, input int n);
      @(posedge sys_clk);
      level <= p;
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic signStep(input logic [23:0] p, input logic e);
      wr(ADDR_IRQ_ST1, 24'h00_00FF);
      hold(p, 20);
      rd2(ADDR_IRQ_ST1, ADDR_IRQ_ST1, d0, d1);
      check(24'(d0[ST_SIGN_BIT]), 24'(e));
      check(24'(measIrq), 24'(e));
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge sys_clk);
      badCount++;
      final_report();
   end

   initial begin
      {nrst, regWr, regRd, negActive, regAddr, regWdata, level} = '0;
      {badCount, nTests, pulses} = '0;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      check(24'(energyPulseN), 24'h00_0001);
      wr(8'h7f, 24'h00_00FF);
      for (int i = 0; i < 6; i++) begin
         rd2(rwAddr[i], 8'h7f, d0, d1);
         check(d0, 24'h00_0000);
         check(d1, 24'h00_0000);
         wrRd(rwAddr[i], 24'h00_00A5, d0);
         check(d0, 24'h00_00A5);
         wr(rwAddr[i], 24'h00_0000);
      end
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_ACC_MODE, accTab[i][0]);
         wr(ADDR_DIVISOR, accTab[i][1]);
         wr(ADDR_GAIN, accTab[i][2]);
         negActive <= accTab[i][3][0];
         rd2(ADDR_ENERGY_RC, ADDR_ENERGY, d0, d1);
         hold(accTab[i][4], 400);
         hold(24'h00_0000, 10);
         rd2(ADDR_ENERGY, ADDR_ENERGY, d0, d1);
         near(d1, accTab[i][5]);
      end
      rd2(ADDR_ENERGY_RC, ADDR_ENERGY, d0, d1);
      near(d0, 24'h00_000A);
      near(d1, 24'h00_0000);
      // the pulse bucket needs far more magnitude than the table rows give
      hold(24'h7F_FFFF, 3000);
      hold(24'h00_0000, 10);
      check(24'(pulses > 0), 24'h00_0001);
      $display("accumulation test done");
      wr(ADDR_ACC_MODE, 24'h00_0000);
      wr(ADDR_IRQ_EN1, 24'h00_0001);
      hold(QP, 20);
      signStep(QN, 1'b1);
      wr(ADDR_IRQ_ST1, 24'h00_00FF);
      @(posedge sys_clk);
      check(24'(measIrq), 24'h00_0000);
      signStep(QP, 1'b0);
      wr(ADDR_ACC_MODE, 24'h00_0001);
      signStep(QN, 1'b0);
      signStep(QP, 1'b1);
      wr(ADDR_ACC_MODE, 24'h00_0000);
      $display("sign test done");
      wr(ADDR_IRQ_EN1, 24'h00_0002);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_NOLOAD_CFG, nlTab[i][0] << NL_FIELD_LSB);
         hold(nlTab[i][1], 10);
         wr(ADDR_IRQ_ST1, 24'h00_00FF);
         repeat (50) @(posedge sys_clk);
         rd2(ADDR_IRQ_ST1, ADDR_IRQ_ST1, d0, d1);
         check(24'(d0[ST_NOLOAD_BIT]), nlTab[i][2]);
         check(24'(measIrq), nlTab[i][2]);
      end
      $display("no-load test done");
      wr(ADDR_OFFSET, 24'h00_0100);
      wr(ADDR_WAVE_RATE, 24'h00_0003);
      wr(ADDR_IRQ_EN3, 24'h00_0001);
      wr(ADDR_IRQ_ST1, 24'h00_00FF);
      hold(QP, 400);
      rd2(ADDR_WAVE_DATA, ADDR_IRQ_ST1, d0, d1);
      check(d0, 24'h40_0001);
      check(24'(d1[ST_WAVE_BIT]), 24'h00_0001);
      $display("waveform test done");
      final_report();
   end
endmodule
